// [bench/pmi_mem_model.sv]
// external memory model sitting on the shared program and data bus
`timescale 1ns/1ps
`default_nettype none
module pmi_mem_model (
    input wire logic ref_clk_i,
    input wire logic [13:0] addr_i,
    input wire logic sel_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [23:0] wdata_i,
    output logic [23:0] rdata_o
);
    // ****************************************
    // storage
    // ****************************************
    logic [23:0] mem [0:255]; // low address bits only, tests avoid aliases
    logic [23:0] last_r = 24'h5A5A5A; // last value driven on the bus
    // write while selected and strobed
    always @(posedge ref_clk_i) begin
        if (!sel_n_i && !wr_n_i) begin
            mem[addr_i[7:0]] <= wdata_i;
        end
        if (!sel_n_i && !rd_n_i) begin
            last_r <= rdata_o;
        end
    end
    // released bus shows the inverse so stale data never passes for a read
    always_comb begin
        if (!sel_n_i && !rd_n_i) begin
            rdata_o = mem[addr_i[7:0]];
        end else begin
            rdata_o = ~last_r;
        end
    end
endmodule
`default_nettype wire

// [bench/pmi_top_tb.sv]
// self-checking bench of the program memory interface
`timescale 1ns/1ps
`default_nettype none
module pmi_top_tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    localparam int CYC = 2; // cycle clock divider under test
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lay = 1'b0;
    logic brn = 1'b1;
    logic pmv = 1'b0;
    logic dmv = 1'b0;
    pmi_pkg::pmi_req_t pmr = '0;
    pmi_pkg::pmi_req_t dmr = '0;
    logic [2:0] wcfg = 3'h0;
    logic wwe = 1'b0;
    logic [7:0] xd = 8'h00;
    logic xwe = 1'b0;
    logic [23:0] din, dout, rdat;
    logic oe, prog_mem_select_n, dms, rdn, wrn, cko, rdy, ack, hit, boot;
    logic [13:0] addr, ffa;
    logic [7:0] px;
    logic [15:0] mst, imk;
    logic [2:0] sp, ws;
    int fail_count = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    pmi_top #(.CYC_DIV(CYC)) i_pmi_top (.ref_clk_i(clk), .sys_rst_i(rst),
        .memory_layout_select_i(lay), .bus_request_n_i(brn), .pm_req_valid_i(pmv),
        .pm_req_i(pmr), .dm_req_valid_i(dmv), .dm_req_i(dmr), .wait_cfg_i(wcfg),
        .wait_cfg_we_i(wwe), .ext_wdata_i(xd), .ext_we_i(xwe), .data_i(din),
        .data_o(dout), .data_oe_o(oe), .addr_o(addr), .prog_mem_select_n_o(prog_mem_select_n),
        .data_mem_select_n_o(dms), .rd_n_o(rdn), .wr_n_o(wrn), .cycle_clock_output_o(cko),
        .req_ready_o(rdy), .ack_o(ack), .int_hit_o(hit), .rdata_o(rdat),
        .prog_word_extension_reg_o(px), .boot_start_o(boot), .first_fetch_addr_o(ffa),
        .mode_status_reg_o(mst), .irq_mask_o(imk), .stack_ptr_o(sp), .wait_states_o(ws));
    pmi_mem_model i_pmi_mem_model (.ref_clk_i(clk), .addr_i(addr), .sel_n_i(prog_mem_select_n & dms),
        .rd_n_i(rdn), .wr_n_i(wrn), .wdata_i(dout), .rdata_o(din));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic hang();
        fail_count++;
        $display("[ERR] %0t wait bound used up", $time);
        give_verdict();
    endtask
    // one access: wait for acceptance, count strobe cycles, take read data at the ack
    task automatic acc(input logic pm, input logic [13:0] a, input logic wr, input logic wd,
                       input logic [23:0] wv, output logic [23:0] rv, output int ns,
                       output logic h);
        int k;
        k = 0;
        ns = 0;
        @(posedge clk);
        if (pm) begin
            pmv <= 1'b1;
            pmr <= {a, wr, wd, wv};
        end else begin
            dmv <= 1'b1;
            dmr <= {a, wr, wd, wv};
        end
        #1;
        while (rdy !== 1'b1) begin
            if (++k > 40) hang();
            @(posedge clk);
            #1;
        end
        h = hit;
        @(posedge clk);
        pmv <= 1'b0;
        dmv <= 1'b0;
        k = 0;
        // the first strobe cycle follows the taking edge directly
        #1;
        while (ack !== 1'b1) begin
            if ((wr ? wrn : rdn) === 1'b0) begin
                ns++;
                chk(pm ? prog_mem_select_n : dms, 0, "select during strobe");
                chk(oe, wr, "bus drive during access");
                chk(addr, a, "address during strobe");
            end
            if (++k > 40) hang();
            @(posedge clk);
            #1;
        end
        rv = rdat;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // reset with given pins; boot pulse expected only for low map and no bus request
    task automatic t_reset(input logic l, input logic b, input logic exp_boot);
        int nb;
        nb = 0;
        @(posedge clk);
        rst <= 1'b1;
        lay <= l;
        brn <= b;
        repeat (12) @(posedge clk);
        chk({rdn, wrn, prog_mem_select_n, dms, oe}, 5'h1E, "pins in reset");
        rst <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (boot === 1'b1) nb++;
        end
        chk(nb, exp_boot, "boot pulses");
        chk(mst, pmi_pkg::MODE_STATUS_RESET, "mode status");
        chk(imk, pmi_pkg::IRQ_MASK_RESET, "irq mask");
        chk(sp, pmi_pkg::STACK_EMPTY, "stack pointer");
        chk(ffa, pmi_pkg::ADDR_ZERO, "first fetch");
        chk(ws, pmi_pkg::WAIT_RESET, "wait default");
        brn <= 1'b1;
        $display("reset test done");
    endtask
    // cycle clock half period after a reset that left the input clock alone
    task automatic t_clk();
        int k;
        logic c0;
        k = 0;
        #1;
        c0 = cko;
        // wait for a toggle, then count input clocks up to the next one
        while (cko === c0) begin
            if (++k > 20) hang();
            @(posedge clk);
            #1;
        end
        c0 = cko;
        k = 0;
        while (cko === c0) begin
            if (++k > 20) hang();
            @(posedge clk);
            #1;
        end
        chk(k, CYC, "cycle clock half period");
        $display("clock test done");
    endtask
    // wide write then read at default, zero, mid and top wait counts
    task automatic t_wait();
        logic [23:0] rv;
        logic h;
        int ns;
        logic [2:0] wl [4] = '{3'h7, 3'h0, 3'h3, 3'h7};
        for (int i = 0; i < 4; i++) begin
            if (i > 0) begin
                @(posedge clk);
                wcfg <= wl[i];
                wwe <= 1'b1;
                @(posedge clk);
                wwe <= 1'b0;
            end
            acc(1, 14'h0810 + 14'(i), 1, 1, 24'hC0FFEE ^ 24'(i), rv, ns, h);
            chk(ns, wl[i] + 1, "write strobe cycles");
            acc(1, 14'h0810 + 14'(i), 0, 1, 24'h0, rv, ns, h);
            chk(ns, wl[i] + 1, "read strobe cycles");
            chk(rv, 24'hC0FFEE ^ 24'(i), "wide read back");
        end
        $display("wait test done");
    endtask
    // extension register feeds narrow writes and catches narrow reads; data side shares bus
    task automatic t_narrow();
        logic [23:0] rv;
        logic h;
        int ns;
        @(posedge clk);
        xd <= 8'hA5;
        xwe <= 1'b1;
        @(posedge clk);
        xwe <= 1'b0;
        acc(1, 14'h0900, 1, 0, 24'h001234, rv, ns, h);
        acc(1, 14'h0900, 0, 1, 24'h0, rv, ns, h);
        chk(rv, 24'h1234A5, "narrow write low byte");
        acc(0, 14'h0901, 1, 1, 24'hBEEF3C, rv, ns, h);
        acc(0, 14'h0901, 0, 1, 24'h0, rv, ns, h);
        chk(rv, 24'hBEEF3C, "data side read");
        acc(1, 14'h0901, 0, 0, 24'h0, rv, ns, h);
        chk(px, 8'h3C, "narrow read low byte");
        $display("narrow test done");
    endtask
    // which addresses stay internal under the current map
    task automatic t_map(input logic [13:0] a, input logic exp_hit);
        logic [23:0] rv;
        logic h;
        int ns;
        acc(1, a, 0, 1, 24'h0, rv, ns, h);
        chk(h, exp_hit, "internal hit");
        // every map test runs at the reset wait count
        chk(ns, exp_hit ? 0 : pmi_pkg::WAIT_RESET + 1, "external strobes");
        $display("map test done");
    endtask
    // no access is accepted while the bus is requested
    task automatic t_busreq();
        int nr;
        nr = 0;
        @(posedge clk);
        brn <= 1'b0;
        repeat (3) @(posedge clk);
        pmv <= 1'b1;
        pmr <= {14'h0820, 1'b0, 1'b1, 24'h0};
        repeat (6) begin
            @(posedge clk);
            #1;
            if (rdy !== 1'b0) nr++;
        end
        chk(nr, 0, "ready under bus request");
        pmv <= 1'b0;
        brn <= 1'b1;
        repeat (3) @(posedge clk);
        t_map(14'h0820, 0);
        $display("bus request test done");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        t_reset(0, 0, 0);
        t_reset(0, 1, 1);
        t_clk();
        t_wait();
        t_narrow();
        t_map(14'h01FF, 1);
        t_map(14'h0800, 0);
        t_busreq();
        t_reset(1, 1, 0);
        t_clk();
        t_map(14'h3800, 1);
        t_map(14'h39FF, 1);
        t_map(14'h3A00, 0);
        t_map(14'h0000, 0);
        give_verdict();
    end
endmodule
`default_nettype wire

// [common/pmi_pkg.sv]
// package: constants and carrier types of the program memory interface
package pmi_pkg;
    // ****************************************
    // bus widths
    // ****************************************
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int REG_W = 16;
    localparam int EXT_W = 8;
    localparam int WAIT_W = 3;
    // ****************************************
    // reset values and map bounds
    // ****************************************
    localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
    localparam logic [ADDR_W-1:0] INT_RAM_WORDS = 14'h0200;
    localparam logic [ADDR_W-1:0] EXT_BASE_LOW_MAP = 14'h0800;
    localparam logic [ADDR_W-1:0] INT_BASE_HIGH_MAP = 14'h3800;
    localparam logic [ADDR_W-1:0] INT_LAST_HIGH_MAP = 14'h39FF;
    localparam logic [15:0] MODE_STATUS_RESET = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
    localparam logic [2:0] STACK_EMPTY = 3'h0;
    // ****************************************
    // request carrier from the core
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic wide;
        logic [DATA_W-1:0] wdata;
    } pmi_req_t;
endpackage

// [rtl/pmi_top.sv]
// file: external program memory interface with reset and clock control
// Function
// - reset input resets whole block; here the layout and bus request synchronisers have no reset
// - later resets keep internal clock running; every reset here clears the cycle clock divider and holds its output low
// - reset empties stacks, masks irqs, clears status
// - boot only without bus request, layout low
// - first fetch from internal address zero; in the high map address zero decodes external here
// - program and data buses share external buses
// - external data bus 24 bits bidirectional
// - external address bus 14 bits
// - program select low during program access
// - write strobe low on external writes
// - read strobe low on external reads
// - extension register supplies low byte writes
// - low byte of 16-bit reads into extension
// - zero to seven waits, seven after reset
// - cycle clock output follows instruction cycles
// - layout select picks one of two maps
// - low map: internal 512 words, external 0x0800
// - high map: external zero, internal 0x3800-0x39FF
`timescale 1ns/1ps
`default_nettype none
module pmi_top #(
    parameter int CYC_DIV = 2
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic memory_layout_select_i,
    input wire logic bus_request_n_i,
    input wire logic pm_req_valid_i,
    input wire pmi_pkg::pmi_req_t pm_req_i,
    input wire logic dm_req_valid_i,
    input wire pmi_pkg::pmi_req_t dm_req_i,
    input wire logic [pmi_pkg::WAIT_W-1:0] wait_cfg_i,
    input wire logic wait_cfg_we_i,
    input wire logic [pmi_pkg::EXT_W-1:0] ext_wdata_i,
    input wire logic ext_we_i,
    input wire logic [pmi_pkg::DATA_W-1:0] data_i,
    output logic [pmi_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic [pmi_pkg::ADDR_W-1:0] addr_o,
    output logic prog_mem_select_n_o,
    output logic data_mem_select_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic cycle_clock_output_o,
    output logic req_ready_o,
    output logic ack_o,
    output logic int_hit_o,
    output logic [pmi_pkg::DATA_W-1:0] rdata_o,
    output logic [pmi_pkg::EXT_W-1:0] prog_word_extension_reg_o,
    output logic boot_start_o,
    output logic [pmi_pkg::ADDR_W-1:0] first_fetch_addr_o,
    output logic [15:0] mode_status_reg_o,
    output logic [15:0] irq_mask_o,
    output logic [2:0] stack_ptr_o,
    output logic [pmi_pkg::WAIT_W-1:0] wait_states_o
);
    // ****************************************
    // types and declarations
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STROBE = 3'b010,
        ST_DONE = 3'b100
    } pmi_state_t;

    pmi_state_t state_r;
    logic map_sel_s1_r, map_sel_s2_r; // layout select synchroniser
    logic br_s1_r, br_s2_r; // bus request synchroniser
    logic map_latched_r; // layout captured after reset release
    logic rst_seen_r; // first cycle after release marker
    logic [pmi_pkg::WAIT_W-1:0] wait_r;
    logic [pmi_pkg::EXT_W-1:0] px_r;
    logic [pmi_pkg::ADDR_W-1:0] addr_r;
    logic [pmi_pkg::DATA_W-1:0] wdata_r;
    logic [pmi_pkg::DATA_W-1:0] rdata_r;
    logic write_r, wide_r, is_prog_r, ack_r, oe_r;
    logic wc_load, wc_done;
    logic [7:0] div_r; // cycle clock divider
    logic cyc_r;
    logic [15:0] mode_status_reg_r, imask_r;
    logic [2:0] sp_r;
    logic boot_r;
    pmi_pkg::pmi_req_t sel_req;
    logic sel_valid, sel_prog, sel_int;

    // true when a program address falls in on-chip ram for the given layout
    function automatic logic is_internal(input logic [pmi_pkg::ADDR_W-1:0] a,
                                         input logic high_map);
        if (!high_map) begin
            is_internal = a < pmi_pkg::INT_RAM_WORDS;
        end else begin
            is_internal = (a >= pmi_pkg::INT_BASE_HIGH_MAP)
                && (a <= pmi_pkg::INT_LAST_HIGH_MAP);
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // no reset here: the pins keep being sampled while reset holds, so the
    // layout and bus request seen at release are the real pin levels
    always_ff @(posedge ref_clk_i) begin
        map_sel_s1_r <= memory_layout_select_i;
        map_sel_s2_r <= map_sel_s1_r;
        br_s1_r <= bus_request_n_i;
        br_s2_r <= br_s1_r;
    end

    // ****************************************
    // reset effects and boot decision
    // ****************************************
    // status cleared, irqs masked, stacks empty while reset holds
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_status_reg_r <= pmi_pkg::MODE_STATUS_RESET;
            imask_r <= pmi_pkg::IRQ_MASK_RESET;
            sp_r <= pmi_pkg::STACK_EMPTY;
        end
    end

    // layout is caught by a clocked process after release, not by the reset
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_seen_r <= 1'b0;
            map_latched_r <= 1'b0;
            boot_r <= 1'b0;
        end else if (!rst_seen_r) begin
            rst_seen_r <= 1'b1;
            map_latched_r <= map_sel_s2_r;
            boot_r <= !map_sel_s2_r && br_s2_r;
        end else begin
            boot_r <= 1'b0;
        end
    end

    // ****************************************
    // cycle clock divider
    // ****************************************
    // divider is reset only with the block; no pll relock modelled
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_r <= 8'h00;
            cyc_r <= 1'b0;
        end else if (div_r == 8'(CYC_DIV - 1)) begin
            div_r <= 8'h00;
            cyc_r <= !cyc_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // ****************************************
    // wait state and extension registers
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_r <= pmi_pkg::WAIT_RESET;
        end else if (wait_cfg_we_i) begin
            wait_r <= wait_cfg_i;
        end
    end

    // read capture has priority over a software load in the same cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            px_r <= '0;
        end else if (state_r == ST_STROBE && wc_done && !write_r && !wide_r && is_prog_r) begin
            px_r <= data_i[pmi_pkg::EXT_W-1:0];
        end else if (ext_we_i) begin
            px_r <= ext_wdata_i;
        end
    end

    // ****************************************
    // request arbitration
    // ****************************************
    // program side wins; data side waits as long as a program request is valid
    always_comb begin
        sel_prog = pm_req_valid_i;
        sel_req = pm_req_valid_i ? pm_req_i : dm_req_i;
        sel_valid = (pm_req_valid_i || dm_req_valid_i) && br_s2_r;
        sel_int = sel_prog && is_internal(sel_req.addr, map_latched_r);
    end
    assign req_ready_o = (state_r == ST_IDLE) && br_s2_r && rst_seen_r;
    assign wc_load = req_ready_o && sel_valid && !sel_int;

    pmi_wait_counter #(.W(pmi_pkg::WAIT_W)) u_wait (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .load_i(wc_load),
        .count_i(wait_r), .done_o(wc_done)
    );

    // ****************************************
    // access sequencer
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            addr_r <= '0;
            wdata_r <= '0;
            write_r <= 1'b0;
            wide_r <= 1'b0;
            is_prog_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (wc_load) begin
                        state_r <= ST_STROBE;
                        addr_r <= sel_req.addr;
                        write_r <= sel_req.write;
                        wide_r <= sel_req.wide;
                        is_prog_r <= sel_prog;
                        oe_r <= sel_req.write;
                        // narrow write: upper 16 from register, low byte from extension
                        wdata_r <= sel_req.wide ? sel_req.wdata
                            : {sel_req.wdata[pmi_pkg::REG_W-1:0], px_r};
                    end
                end
                ST_STROBE: begin
                    if (wc_done) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                    oe_r <= 1'b0;
                end
            endcase
        end
    end

    // read data capture and completion pulse
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= '0;
            ack_r <= 1'b0;
        end else begin
            ack_r <= (state_r == ST_STROBE && wc_done) || (wc_load == 1'b0
                && req_ready_o && sel_valid && sel_int);
            if (state_r == ST_STROBE && wc_done && !write_r) begin
                rdata_r <= data_i;
            end
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    always_comb begin
        prog_mem_select_n_o = !(state_r == ST_STROBE && is_prog_r);
        data_mem_select_n_o = !(state_r == ST_STROBE && !is_prog_r);
        rd_n_o = !(state_r == ST_STROBE && !write_r);
        wr_n_o = !(state_r == ST_STROBE && write_r);
    end
    assign data_o = wdata_r;
    assign data_oe_o = oe_r;
    assign addr_o = addr_r;
    assign ack_o = ack_r;
    assign int_hit_o = sel_int;
    assign rdata_o = rdata_r;
    assign prog_word_extension_reg_o = px_r;
    assign cycle_clock_output_o = cyc_r;
    assign boot_start_o = boot_r;
    assign first_fetch_addr_o = pmi_pkg::ADDR_ZERO;
    assign mode_status_reg_o = mode_status_reg_r;
    assign irq_mask_o = imask_r;
    assign stack_ptr_o = sp_r;
    assign wait_states_o = wait_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_strobe_len;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && wait_r == 3'h0) |=> (state_r == ST_STROBE) ##1 (state_r == ST_DONE);
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("zero wait strobe not one cycle");
    property p_seven_waits;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && wait_r == 3'h7) |=> (!rd_n_o || !wr_n_o) [*8] ##1 (rd_n_o && wr_n_o);
    endproperty
    a_seven_waits: assert property (p_seven_waits) else $error("seven waits wrong length");
    property p_pms;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && sel_prog) |=> !prog_mem_select_n_o && data_mem_select_n_o;
    endproperty
    a_pms: assert property (p_pms) else $error("program select missing");
    property p_wr;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && sel_req.write) |=> !wr_n_o && rd_n_o && data_oe_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe missing");
    property p_rd;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && !sel_req.write) |=> !rd_n_o && wr_n_o && !data_oe_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe missing");
    property p_px_write;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wc_load && sel_req.write && !sel_req.wide)
        |=> data_o[pmi_pkg::EXT_W-1:0] == $past(px_r);
    endproperty
    a_px_write: assert property (p_px_write) else $error("low byte not from extension");
    property p_px_read;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_r == ST_STROBE && wc_done && !write_r && !wide_r && is_prog_r)
        |=> px_r == $past(data_i[pmi_pkg::EXT_W-1:0]);
    endproperty
    a_px_read: assert property (p_px_read) else $error("extension not loaded");
    property p_low_map;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (pm_req_valid_i && !map_latched_r && pm_req_i.addr >= pmi_pkg::EXT_BASE_LOW_MAP)
        |-> !int_hit_o;
    endproperty
    a_low_map: assert property (p_low_map) else $error("low map external decoded internal");
    property p_high_map;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (pm_req_valid_i && map_latched_r && pm_req_i.addr == pmi_pkg::INT_LAST_HIGH_MAP)
        |-> int_hit_o;
    endproperty
    a_high_map: assert property (p_high_map) else $error("high map internal missed");
    property p_boot;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        boot_start_o |-> !map_latched_r && $past(rst_seen_r) == 1'b0;
    endproperty
    a_boot: assert property (p_boot) else $error("boot in wrong layout");

    c_read: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wc_load && !sel_req.write);
    c_write: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wc_load && sel_req.write);
    c_boot: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) boot_start_o);
endmodule
`default_nettype wire

// [rtl/pmi_wait_counter.sv]
// file: wait state counter for one external access
`timescale 1ns/1ps
`default_nettype none
module pmi_wait_counter #(
    parameter int W = 3
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt_r; // remaining extra cycles
    logic busy_r; // counting in progress
    // ****************************************
    // countdown
    // ****************************************
    // one extra strobe cycle per wait state
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (load_i) begin
            cnt_r <= count_i;
            busy_r <= 1'b1;
        end else if (busy_r && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end else begin
            busy_r <= 1'b0;
        end
    end
    // done in the last strobe cycle
    assign done_o = busy_r && (cnt_r == '0);
endmodule
`default_nettype wire
